// ==== hdl/rwr_remapper.sv ====
// Purpose: direct-address window remapping for the lower register file
// Assumes: cpu presents one operand address per cycle; register writes by byte address
// Notes: address translation is combinational, register data is flopped
`timescale 1ns/1ns
`include "rwr_regs.svh"
module rwr_remapper
  import rwr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_pop_all_instr,
  input wire logic [7:0] i_pop_all_data,
  output logic [7:0] o_push_all_data,
  input wire logic i_op_valid,
  input wire logic i_op_direct,
  input wire logic [15:0] i_op_addr,
  output logic [15:0] o_op_addr,
  output logic o_op_remapped,
  output logic o_bus_hold_enable
);
  logic [7:0] primary_window_select;
  logic [7:0] secondary_window_select;
  logic [7:0] next_primary;
  logic [7:0] next_secondary;

  wire logic wr_pri = i_reg_wr && (i_reg_addr == `RWR_PRI_ADDR);
  wire logic wr_sec = i_reg_wr && (i_reg_addr == `RWR_SEC_ADDR);

  // pop-all reloads only the primary register
  always_comb begin
    next_primary = primary_window_select;
    next_secondary = secondary_window_select;
    if (i_pop_all_instr) begin
      next_primary = i_pop_all_data;
    end else if (wr_pri) begin
      next_primary = i_reg_wdata;
    end
    if (wr_sec) begin
      next_secondary = i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      primary_window_select <= `RWR_PRI_RESET;
      secondary_window_select <= `RWR_SEC_RESET;
    end else begin
      primary_window_select <= next_primary;
      secondary_window_select <= next_secondary;
    end
  end

  wire logic [6:0] primary_window_code = primary_window_select[6:0];
  wire logic [7:0] secondary_window_code = secondary_window_select;
  wire logic [7:0] pcode = {1'b0, primary_window_code};

  // primary decode, 128-byte codes allowed
  wire logic p_sfr32 =
    (pcode >= `RWR_PSFR_LO32) && (pcode <= `RWR_PSFR_HI32);
  wire logic p_sfr64 =
    (pcode >= `RWR_PSFR_LO64) && (pcode <= `RWR_PSFR_HI64);
  wire logic p_sfr128 =
    (pcode >= `RWR_PSFR_LO128) && (pcode <= `RWR_PSFR_HI128);
  wire logic p_urf32 =
    (pcode >= `RWR_URF_LO32) && (pcode <= `RWR_URF_HI32);
  wire logic p_urf64 =
    (pcode >= `RWR_URF_LO64) && (pcode <= `RWR_URF_HI64);
  wire logic p_urf128 =
    (pcode >= `RWR_URF_LO128) && (pcode <= `RWR_URF_HI128);

  wire logic [15:0] p_seg_sfr32 =
    `RWR_PSFR_ORG + {3'h0, pcode, 5'h00};
  wire logic [15:0] p_seg_sfr64 =
    `RWR_PSFR_ORG + {2'h0, pcode, 6'h00};
  wire logic [15:0] p_seg_sfr128 =
    `RWR_PSFR_ORG + {1'h0, pcode, 7'h00};
  wire logic [15:0] p_seg_urf32 =
    `RWR_URF_ORG + {3'h0, pcode, 5'h00} - `RWR_URF_BIAS;
  wire logic [15:0] p_seg_urf64 =
    `RWR_URF_ORG + {2'h0, pcode, 6'h00} - `RWR_URF_BIAS;
  wire logic [15:0] p_seg_urf128 =
    `RWR_URF_ORG + {1'h0, pcode, 7'h00} - `RWR_URF_BIAS;

  wire logic [1:0] psz =
    (p_sfr32 || p_urf32) ? rwr_size32 :
    (p_sfr64 || p_urf64) ? rwr_size64 :
    (p_sfr128 || p_urf128) ? rwr_size128 :
    rwr_none;

  wire logic [15:0] pseg =
    p_sfr32 ? p_seg_sfr32 :
    p_sfr64 ? p_seg_sfr64 :
    p_sfr128 ? p_seg_sfr128 :
    p_urf32 ? p_seg_urf32 :
    p_urf64 ? p_seg_urf64 :
    p_urf128 ? p_seg_urf128 :
    `RWR_NO_SEG;

  // secondary decode, no 128-byte codes, adds code ram and external
  wire logic s_sfr32 =
    (secondary_window_code >= `RWR_PSFR_LO32) && (secondary_window_code <= `RWR_PSFR_HI32);
  wire logic s_sfr64 =
    (secondary_window_code >= `RWR_PSFR_LO64) && (secondary_window_code <= `RWR_PSFR_HI64);
  wire logic s_urf32 =
    (secondary_window_code >= `RWR_URF_LO32) && (secondary_window_code <= `RWR_URF_HI32);
  wire logic s_urf64 =
    (secondary_window_code >= `RWR_URF_LO64) && (secondary_window_code <= `RWR_URF_HI64);
  wire logic s_cram =
    (secondary_window_code >= `RWR_CRAM_LO) && (secondary_window_code <= `RWR_CRAM_HI);
  wire logic s_xmem =
    (secondary_window_code >= `RWR_XMEM_LO) && (secondary_window_code <= `RWR_XMEM_HI);

  wire logic [15:0] s_seg_sfr32 =
    `RWR_PSFR_ORG + {3'h0, secondary_window_code, 5'h00};
  wire logic [15:0] s_seg_sfr64 =
    `RWR_PSFR_ORG + {2'h0, secondary_window_code, 6'h00};
  wire logic [15:0] s_seg_urf32 =
    `RWR_URF_ORG + {3'h0, secondary_window_code, 5'h00} - `RWR_URF_BIAS;
  wire logic [15:0] s_seg_urf64 =
    `RWR_URF_ORG + {2'h0, secondary_window_code, 6'h00} - `RWR_URF_BIAS;
  wire logic [15:0] s_seg_cram =
    `RWR_CRAM_ORG + {2'h0, secondary_window_code, 6'h00};
  wire logic [15:0] s_seg_xmem =
    `RWR_XMEM_ORG + {2'h0, secondary_window_code, 6'h00};

  wire logic [1:0] ssz =
    (s_sfr32 || s_urf32) ? rwr_size32 :
    (s_sfr64 || s_urf64 || s_cram || s_xmem) ? rwr_size64 :
    rwr_none;

  wire logic [15:0] sseg =
    s_sfr32 ? s_seg_sfr32 :
    s_sfr64 ? s_seg_sfr64 :
    s_urf32 ? s_seg_urf32 :
    s_urf64 ? s_seg_urf64 :
    s_cram ? s_seg_cram :
    s_xmem ? s_seg_xmem :
    `RWR_NO_SEG;

  // window bases in the lower file
  wire logic [15:0] pbase = (psz == rwr_size128) ? `RWR_PRI_BASE128 :
                            (psz == rwr_size64) ? `RWR_PRI_BASE64 : `RWR_PRI_BASE32;
  wire logic [15:0] sbase = (ssz == rwr_size64) ? `RWR_SEC_BASE64 : `RWR_SEC_BASE32;
  wire logic [15:0] ptop = `RWR_PRI_BASE32 + `RWR_SPAN32;
  wire logic [15:0] stop = `RWR_SEC_BASE32 + `RWR_SPAN32;

  wire logic phit = (psz != rwr_none) && i_op_addr >= pbase && i_op_addr <= ptop;
  wire logic shit = (ssz != rwr_none) && i_op_addr >= sbase && i_op_addr <= stop;
  wire logic use_win = i_op_valid && i_op_direct && (phit || shit);
  wire logic [15:0] poff = i_op_addr - pbase;
  wire logic [15:0] soff = i_op_addr - sbase;
  wire logic [15:0] paddr = pseg + poff;
  wire logic [15:0] saddr = sseg + soff;

  assign o_op_addr = !use_win ? i_op_addr : (phit ? paddr : saddr);
  assign o_op_remapped = use_win;
  assign o_bus_hold_enable = primary_window_select[`RWR_HOLD_BIT];
  assign o_push_all_data = primary_window_select;
  assign o_reg_rdata = (i_reg_addr == `RWR_PRI_ADDR) ? primary_window_select :
                       (i_reg_addr == `RWR_SEC_ADDR) ? secondary_window_select : 8'h00;
endmodule : rwr_remapper

// ==== hdl/rwr_regs.svh ====
// Purpose: constants for the register window remapper
// Assumes: byte-wide window-select registers in the lower register file
// Notes: addresses are 16-bit byte addresses
`ifndef RWR_REGS_SVH
`define RWR_REGS_SVH
`define RWR_PRI_ADDR 16'h0014
`define RWR_SEC_ADDR 16'h0015
`define RWR_PRI_RESET 8'h00
`define RWR_SEC_RESET 8'h00
`define RWR_HOLD_BIT 7
`define RWR_PRI_BASE32 16'h00e0
`define RWR_PRI_BASE64 16'h00c0
`define RWR_PRI_BASE128 16'h0080
`define RWR_SEC_BASE32 16'h0060
`define RWR_SEC_BASE64 16'h0040
`define RWR_PSFR_LO32 8'h7a
`define RWR_PSFR_HI32 8'h7f
`define RWR_PSFR_LO64 8'h3d
`define RWR_PSFR_HI64 8'h3f
`define RWR_PSFR_LO128 8'h1e
`define RWR_PSFR_HI128 8'h1f
`define RWR_URF_LO32 8'h48
`define RWR_URF_HI32 8'h4f
`define RWR_URF_LO64 8'h24
`define RWR_URF_HI64 8'h27
`define RWR_URF_LO128 8'h12
`define RWR_URF_HI128 8'h13
`define RWR_CRAM_LO 8'ha0
`define RWR_CRAM_HI 8'hbf
`define RWR_XMEM_LO 8'h80
`define RWR_XMEM_HI 8'h9f
`define RWR_PSFR_ORG 16'h1000
`define RWR_URF_ORG 16'h0000
`define RWR_CRAM_ORG 16'hd000
`define RWR_URF_BIAS 16'h0800
`define RWR_SPAN32 16'h001f
`define RWR_NO_SEG 16'h0000
`define RWR_XMEM_ORG 16'hd000
`endif

// ==== hdl/rwr_pkg.sv ====
// Purpose: types for the register window remapper
// Assumes: nothing
// Notes: window size encoding
package rwr_pkg;
  typedef enum logic [1:0] {
    rwr_none,
    rwr_size32,
    rwr_size64,
    rwr_size128
  } rwr_size_type;
endpackage : rwr_pkg

// ==== testbench/rwr_properties.sv ====
// Purpose: port assertions for the remapper; Assumes: top ports only; Notes: bound below
`timescale 1ns/1ns
module rwr_properties (
  input wire logic i_clk_sys, i_sys_rst, i_reg_wr, i_pop_all_instr, i_op_valid, i_op_direct,
  input wire logic o_op_remapped, o_bus_hold_enable,
  input wire logic [15:0] i_reg_addr, i_op_addr, o_op_addr,
  input wire logic [7:0] i_reg_wdata, i_pop_all_data, o_push_all_data);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  hold_bit_a: assert property (o_bus_hold_enable == o_push_all_data[7])
    else $error("hold enable differs");
  pri_write_a: assert property (i_reg_wr && i_reg_addr == 16'h0014 && !i_pop_all_instr
    |=> o_push_all_data == $past(i_reg_wdata)) else $error("primary write lost");
  pop_load_a: assert property (i_pop_all_instr |=> o_push_all_data == $past(i_pop_all_data))
    else $error("pop not loaded");
  reset_zero_a: assert property ($past(i_sys_rst) |-> o_push_all_data == 8'h00)
    else $error("primary not zero");
  indirect_pass_a: assert property (i_op_valid && !i_op_direct
    |-> !o_op_remapped && o_op_addr == i_op_addr) else $error("indirect remapped");
  window_span_a: assert property (o_op_remapped
    |-> i_op_direct && i_op_addr >= 16'h0040 && i_op_addr <= 16'h00ff) else $error("bad span");
  offset_keep_a: assert property (o_op_remapped |-> o_op_addr[4:0] == i_op_addr[4:0])
    else $error("offset lost");
  plain_pass_a: assert property (!o_op_remapped |-> o_op_addr == i_op_addr)
    else $error("address altered");
endmodule : rwr_properties
bind rwr_remapper rwr_properties u_rwr_properties (.*);

// ==== testbench/rwr_cpu_model.sv ====
// Purpose: cpu operand path model; Assumes: one access a cycle; Notes: idle address toggles
`timescale 1ns/1ns
module rwr_cpu_model (
  input wire logic i_clk_sys, i_sys_rst, i_req, i_dir, input wire logic [15:0] i_addr,
  output logic o_op_valid, o_op_direct, output logic [15:0] o_op_addr);
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) {o_op_valid, o_op_direct, o_op_addr} <= '0;
    else {o_op_valid, o_op_direct, o_op_addr} <= {i_req, i_dir, i_req ? i_addr : ~o_op_addr};
endmodule : rwr_cpu_model

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench; Assumes: rwr_remapper; Notes: model checks every operand access, register reads use fixed values
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic i_clk_sys = 0, i_sys_rst = 1, i_reg_wr = 0, i_pop_all_instr = 0, req = 0, dir = 0;
  logic [15:0] i_reg_addr = 0, adr = 0, i_op_addr, o_op_addr;
  logic [7:0] i_reg_wdata = 0, i_pop_all_data = 0, o_reg_rdata, o_push_all_data;
  logic i_op_valid, i_op_direct, o_op_remapped, o_bus_hold_enable;
  int fail_count = 0, tests_run = 0, rnd = 88167, pri = 0, sec = 0;
  byte unsigned pl[12] = '{8'h13, 8'h12, 8'h4a, 8'h7f, 8'h3e, 8'h1e, 8'h27, 8'h93, 8'h55, 8'h80, 0, 8'h7a};
  byte unsigned sl[12] = '{8'h3e, 8'hbf, 8'ha0, 8'h80, 8'h9f, 8'h1f, 8'h48, 8'h4f, 8'h55, 8'h24, 0, 8'h7d};
  rwr_remapper u_rwr_remapper (.*);
  rwr_cpu_model u_rwr_cpu_model (.i_clk_sys, .i_sys_rst, .i_req(req), .i_dir(dir), .i_addr(adr),
    .o_op_valid(i_op_valid), .o_op_direct(i_op_direct), .o_op_addr(i_op_addr));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  function automatic int lfsr(int s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr
  function automatic int seg(int c, int p, output int sg);
    if (c >= 'h7a && c <= 'h7f) begin sg = 'h1000 + c * 32; return 32; end
    if (c >= 'h48 && c <= 'h4f) begin sg = c * 32 - 'h800; return 32; end
    if (c >= 'h3d && c <= 'h3f) begin sg = 'h1000 + c * 64; return 64; end
    if (c >= 'h24 && c <= 'h27) begin sg = c * 64 - 'h800; return 64; end
    if (p && c >= 'h1e && c <= 'h1f) begin sg = 'h1000 + c * 128; return 128; end
    if (p && c >= 'h12 && c <= 'h13) begin sg = c * 128 - 'h800; return 128; end
    if (!p && c >= 'h80 && c <= 'h9f) begin sg = 'hd000 + c * 64; return 64; end
    if (!p && c >= 'ha0 && c <= 'hbf) begin sg = 'hf800 + (c - 'ha0) * 64; return 64; end
    sg = 0;
    return 0;
  endfunction : seg
  function automatic logic [16:0] exp_map(int d, int a);
    int sz, sg;
    sz = seg(pri & 127, 1, sg);
    if (d && sz > 0 && a >= 256 - sz && a < 256) return {1'b1, 16'(sg + a - 256 + sz)};
    sz = seg(sec, 0, sg);
    if (d && sz > 0 && a >= 128 - sz && a < 128) return {1'b1, 16'(sg + a - 128 + sz)};
    return {1'b0, 16'(a)};
  endfunction : exp_map
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge i_clk_sys) begin i_reg_wr <= 1; i_reg_addr <= a; i_reg_wdata <= d; end
    @(posedge i_clk_sys) i_reg_wr <= 0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge i_clk_sys) i_reg_addr <= a;
    @(negedge i_clk_sys) `CHK(o_reg_rdata, e)
  endtask : rd
  task automatic acc(logic d, logic [15:0] a);
    @(posedge i_clk_sys) begin req <= 1; dir <= d; adr <= a; end
    @(posedge i_clk_sys) req <= 0;
    @(negedge i_clk_sys) `CHK({o_op_remapped, o_op_addr}, exp_map(d, a))
  endtask : acc
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 0;
    rd(16'h0014, 8'h00);
    rd(16'h0016, 8'h00);
    foreach (pl[i]) begin
      wr(16'h0014, pl[i]);
      wr(16'h0015, sl[i]);
      pri = pl[i];
      sec = sl[i];
      rd(16'h0014, pl[i]);
      rd(16'h0015, sl[i]);
      `CHK(o_bus_hold_enable, pl[i][7])
      `CHK(o_push_all_data, pl[i])
      for (int k = 0; k < 16; k++) begin
        rnd = lfsr(rnd);
        acc(rnd[8] | k[1], 16'(k * 16 + (k[0] ? 15 : 0)));
        acc(rnd[9], 16'(rnd[7:0]));
      end
      $display("codes %h %h done", pl[i], sl[i]);
    end
    @(posedge i_clk_sys) begin
      i_pop_all_instr <= 1; i_pop_all_data <= 8'h3d; i_reg_wr <= 1; i_reg_wdata <= 8'h12;
      i_reg_addr <= 16'h0014;
    end
    @(posedge i_clk_sys) begin i_pop_all_instr <= 0; i_reg_wr <= 0; end
    pri = 8'h3d;
    rd(16'h0014, 8'h3d);
    rd(16'h0015, 8'h7d);
    acc(1, 16'h00c5);
    acc(1, 16'h0065);
    $display("pop test done");
    tally_and_finish();
  end
endmodule : testbench
